// *** mfci_top.sv ***
/*
  Device end of a managed flash card bus: command receiver, identity
  response, bus width and pull-up control, hardware reset, byte stream
  serializer and a small block mapper with spare replacement.
  Assumes the host clocks the bus on i_bus_clk and that core-side users
  run on i_ref_clk; the pad ring resolves the three-signal pins.
*/
`timescale 1ns/1ps
`default_nettype none
module mfci_top
  import mfci_pkg::*;
#(
  parameter logic [7:0]  MAKER_CODE   = 8'h5a,            // Arbitrary value.
  parameter logic [47:0] PRODUCT_NAME = 48'h0123_4567_89ab, // Arbitrary value.
  parameter logic [31:0] SERIAL_NO    = 32'h0000_0001,
  parameter logic [7:0]  OEM_CODE     = 8'h00,
  parameter logic [7:0]  REVISION     = 8'h10,
  parameter logic [7:0]  BUILD_DATE   = 8'h00,
  parameter logic [1:0]  PKG_TYPE     = 2'h1,
  parameter int          SPARES       = 4,
  parameter int          BLK_W        = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_srst,
  input  wire logic             i_bus_clk,
  input  wire logic             i_hw_rst_n,
  input  wire logic             i_cmd_in,
  output logic                  o_cmd_out,
  output logic                  o_cmd_oe,
  input  wire logic [7:0]       i_dat_in,
  output logic      [7:0]       o_dat_out,
  output logic      [7:0]       o_dat_oe,
  output logic      [6:0]       o_pull_en,
  input  wire logic [7:0]       i_wr_data,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  output logic                  o_ecc_err,
  input  wire logic             i_bad_valid,
  input  wire logic [BLK_W-1:0] i_bad_blk,
  input  wire logic             i_erase_done,
  input  wire logic             i_map_req,
  input  wire logic [BLK_W-1:0] i_map_lba,
  output logic      [BLK_W:0]   o_map_pba,
  output logic                  o_map_valid
);

  localparam int SLOT_W = (SPARES > 1) ? $clog2(SPARES) : 1;
  localparam logic [SLOT_W:0] SPARE_CNT = (SLOT_W+1)'(SPARES);

  if (SPARES < 1 || SLOT_W > BLK_W || BLK_W < 2) begin : g_bad_cfg
    $error("mfci_top: SPARES or BLK_W out of range");
  end

  // A pin reset may last a single bus cycle, and its flush level crosses into the
  // core as a plain level, so the core must run at least as fast as the bus limit.
  if (CORE_CLK_MHZ < BUS_MAX_MHZ) begin : g_bad_clk
    $error("mfci_top: core clock slower than the bus clock limit");
  end

  // ----------------------------------------------------------------
  // Identity register
  // ----------------------------------------------------------------
  function automatic logic [6:0] mfci_crc7(input logic [119:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction

  localparam logic [119:0] ID_BODY = {MAKER_CODE, 6'h00, PKG_TYPE, OEM_CODE,
                                      PRODUCT_NAME, REVISION, SERIAL_NO, BUILD_DATE};
  localparam logic [127:0] CARD_ID = {ID_BODY, mfci_crc7(ID_BODY), 1'b1};

  // ----------------------------------------------------------------
  // Core side: two-entry buffer with parity, toggle handshake out
  // ----------------------------------------------------------------
  logic [8:0] buf_mem [2];
  logic       buf_wp_r;
  logic       buf_rp_r;
  logic [1:0] buf_cnt_r;
  logic [1:0] buf_cnt_nxt;
  logic [7:0] xfer_r;
  logic       req_tgl_r;
  logic       ack_s1;
  logic       ack_s2;
  logic       hwr_s1;
  logic       hwr_s2;
  logic       ack_tgl_r;
  logic       lhw_rst_r;
  logic       push;
  logic       pop;

  assign push        = i_wr_valid & o_wr_ready;
  assign pop         = (buf_cnt_r != 2'h0) & (req_tgl_r == ack_s2);
  assign buf_cnt_nxt = buf_cnt_r + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge i_ref_clk) begin
    ack_s1 <= ack_tgl_r;
    ack_s2 <= ack_s1;
    hwr_s1 <= lhw_rst_r;
    hwr_s2 <= hwr_s1;
  end

  // A hardware reset empties the buffer but leaves the handshake alone,
  // so the two toggles never fall out of step.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || hwr_s2) begin
      buf_wp_r   <= 1'b0;
      buf_rp_r   <= 1'b0;
      buf_cnt_r  <= 2'h0;
      o_wr_ready <= 1'b1;
    end else begin
      buf_wp_r   <= buf_wp_r ^ push;
      buf_rp_r   <= buf_rp_r ^ pop;
      buf_cnt_r  <= buf_cnt_nxt;
      o_wr_ready <= (buf_cnt_nxt != 2'h2);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      buf_mem[buf_wp_r] <= {^i_wr_data, i_wr_data};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      req_tgl_r <= 1'b0;
      xfer_r    <= 8'h00;
      o_ecc_err <= 1'b0;
    end else begin
      o_ecc_err <= pop & (^buf_mem[buf_rp_r]);
      if (pop) begin
        xfer_r    <= buf_mem[buf_rp_r][7:0];
        req_tgl_r <= ~req_tgl_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core side: block mapper, spare substitution and wear rotation
  // ----------------------------------------------------------------
  logic [BLK_W-1:0]  bad_tbl [SPARES];
  logic [SPARES-1:0] bad_vld_r;
  logic [SLOT_W:0]   fill_r;
  logic [BLK_W-1:0]  wear_r;
  logic [BLK_W-1:0]  map_phys;
  logic              map_hit;
  logic [SLOT_W-1:0] map_slot;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      bad_vld_r <= '0;
      fill_r    <= '0;
    end else if (i_bad_valid && fill_r < SPARE_CNT) begin
      bad_tbl[fill_r[SLOT_W-1:0]]   <= i_bad_blk;
      bad_vld_r[fill_r[SLOT_W-1:0]] <= 1'b1;
      fill_r                        <= fill_r + (SLOT_W+1)'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wear_r <= '0;
    end else if (i_erase_done) begin
      wear_r <= wear_r + BLK_W'(1);
    end
  end

  always_comb begin
    map_phys = i_map_lba + wear_r;
    map_hit  = 1'b0;
    map_slot = '0;
    for (int k = 0; k < SPARES; k++) begin
      if (bad_vld_r[k] && bad_tbl[k] == map_phys) begin
        map_hit  = 1'b1;
        map_slot = SLOT_W'(k);
      end
    end
  end

  // Spares sit above the user range, so substitution costs no capacity.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_map_pba   <= '0;
      o_map_valid <= 1'b0;
    end else begin
      o_map_valid <= i_map_req;
      if (i_map_req) begin
        o_map_pba <= map_hit ? {1'b1, BLK_W'(map_slot)} : {1'b0, map_phys};
      end
    end
  end

  // ----------------------------------------------------------------
  // Link side: reset and handshake synchronisers
  // ----------------------------------------------------------------
  logic         lrst_s1;
  logic         lrst_s2;
  logic         hwp_s1;
  logic         hwp_s2;
  logic         req_s1;
  logic         req_s2;
  logic         lrst;
  logic         hwrst_en_r;
  mfci_lstate_t lstate_r;
  mfci_width_t  width_r;
  logic         push_pull_r;
  logic [47:0]  cmd_sr;
  logic [5:0]   cmd_cnt_r;
  logic [1:0]   gap_r;
  logic [135:0] rsp_sr;
  logic [7:0]   rsp_left_r;
  logic [7:0]   dtx_sr;
  logic [3:0]   dtx_left_r;
  logic         dtx_busy_r;
  logic [7:0]   lanes;
  logic [3:0]   beats;
  logic [7:0]   beat_val;
  logic [7:0]   beat_shift;

  always_ff @(posedge i_bus_clk) begin
    lrst_s1 <= i_srst;
    lrst_s2 <= lrst_s1;
    hwp_s1  <= i_hw_rst_n;
    hwp_s2  <= hwp_s1;
    req_s1  <= req_tgl_r;
    req_s2  <= req_s1;
  end

  // The reset pin only counts once software has armed it.
  assign lrst = lrst_s2 | (hwrst_en_r & ~hwp_s2);

  always_ff @(posedge i_bus_clk) begin
    if (lrst_s2) begin
      hwrst_en_r <= 1'b0;
      lhw_rst_r  <= 1'b0;
    end else begin
      lhw_rst_r <= hwrst_en_r & ~hwp_s2;
      if (lstate_r == L_GAP && gap_r == 2'h0 && cmd_sr[45:40] == IDX_SWITCH &&
          cmd_sr[33:32] == SW_WRITE_BYTE && cmd_sr[31:24] == ECB_HWRST_EN &&
          cmd_sr[17:16] == HWRST_ON) begin
        hwrst_en_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link side: command receiver, decoder and response driver
  // ----------------------------------------------------------------
  // Only card bus framing is decoded; there is no SPI select path.
  always_ff @(posedge i_bus_clk) begin
    if (lrst) begin
      lstate_r    <= L_IDLE;
      width_r     <= MFCI_W1;
      push_pull_r <= 1'b0;
      cmd_sr      <= '0;
      cmd_cnt_r   <= 6'h00;
      gap_r       <= 2'h0;
      rsp_sr      <= '0;
      rsp_left_r  <= 8'h00;
      o_cmd_out   <= 1'b0;
      o_cmd_oe    <= 1'b0;
    end else begin
      unique case (lstate_r)
        L_IDLE: begin
          o_cmd_oe <= 1'b0;
          if (!i_cmd_in) begin
            cmd_sr    <= {cmd_sr[46:0], i_cmd_in};
            cmd_cnt_r <= CMD_LEN - 6'h2;
            lstate_r  <= L_RX;
          end
        end
        L_RX: begin
          cmd_sr    <= {cmd_sr[46:0], i_cmd_in};
          cmd_cnt_r <= cmd_cnt_r - 6'h1;
          if (cmd_cnt_r == 6'h0) begin
            gap_r    <= 2'h0;
            lstate_r <= L_GAP;
          end
        end
        L_GAP: begin
          gap_r <= gap_r + 2'h1;
          if (gap_r == 2'h0) begin
            if (!cmd_sr[46] || !cmd_sr[0]) begin
              lstate_r <= L_IDLE;
            end else if (cmd_sr[45:40] == IDX_GO_IDLE) begin
              width_r     <= MFCI_W1;
              push_pull_r <= 1'b0;
              lstate_r    <= L_IDLE;
            end else if (cmd_sr[45:40] == IDX_SET_ADDR) begin
              push_pull_r <= 1'b1;
              lstate_r    <= L_IDLE;
            end else if (cmd_sr[45:40] == IDX_SWITCH) begin
              if (cmd_sr[33:32] == SW_WRITE_BYTE && cmd_sr[31:24] == ECB_BUS_WIDTH &&
                  cmd_sr[17:16] != 2'h3) begin
                width_r <= mfci_width_t'(cmd_sr[17:16]);
              end
              lstate_r <= L_IDLE;
            end else if (cmd_sr[45:40] == IDX_SEND_ID) begin
              rsp_sr     <= {2'b00, RSP_RSVD, CARD_ID[127:1], 1'b1};
              rsp_left_r <= RSP_LONG_LEN;
            end else begin
              lstate_r <= L_IDLE;
            end
          end else if (gap_r == NCR_CYC - 2'h1) begin
            lstate_r <= L_RSP;
          end
        end
        L_RSP: begin
          if (rsp_left_r == 8'h00) begin
            o_cmd_oe <= 1'b0;
            lstate_r <= L_IDLE;
          end else begin
            rsp_sr     <= {rsp_sr[134:0], 1'b0};
            rsp_left_r <= rsp_left_r - 8'h1;
            // Open-drain only pulls low; the bus pull-up makes the ones.
            o_cmd_out  <= push_pull_r ? rsp_sr[135] : 1'b0;
            o_cmd_oe   <= push_pull_r | ~rsp_sr[135];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link side: lane selection and byte serializer
  // ----------------------------------------------------------------
  always_comb begin
    unique case (width_r)
      MFCI_W4: begin
        lanes      = LANES_W4;
        beats      = 4'h2;
        beat_val   = {4'h0, dtx_sr[7:4]};
        beat_shift = {dtx_sr[3:0], 4'h0};
      end
      MFCI_W8: begin
        lanes      = LANES_W8;
        beats      = 4'h1;
        beat_val   = dtx_sr;
        beat_shift = 8'h00;
      end
      default: begin
        lanes      = LANES_W1;
        beats      = 4'h8;
        beat_val   = {7'h00, dtx_sr[7]};
        beat_shift = {dtx_sr[6:0], 1'b0};
      end
    endcase
  end

  // Each byte goes out as start beat, data beats, end beat. A width
  // change in mid byte is not guarded; the host switches between blocks.
  always_ff @(posedge i_bus_clk) begin
    if (lrst) begin
      dtx_busy_r <= 1'b0;
      dtx_sr     <= 8'h00;
      dtx_left_r <= 4'h0;
      // A pin reset answers any waiting request, so no stale byte goes out later.
      ack_tgl_r  <= lrst_s2 ? 1'b0 : req_s2;
      o_dat_out  <= 8'h00;
      o_dat_oe   <= 8'h00;
    end else if (!dtx_busy_r) begin
      o_dat_oe <= 8'h00;
      if (req_s2 != ack_tgl_r) begin
        ack_tgl_r  <= req_s2;
        dtx_sr     <= xfer_r;
        dtx_left_r <= beats + 4'h1;
        dtx_busy_r <= 1'b1;
        o_dat_out  <= 8'h00;
        o_dat_oe   <= lanes;
      end
    end else if (dtx_left_r > 4'h1) begin
      o_dat_out  <= beat_val & lanes;
      o_dat_oe   <= lanes;
      dtx_sr     <= beat_shift;
      dtx_left_r <= dtx_left_r - 4'h1;
    end else if (dtx_left_r == 4'h1) begin
      o_dat_out  <= lanes;
      dtx_left_r <= 4'h0;
    end else begin
      o_dat_oe   <= 8'h00;
      dtx_busy_r <= 1'b0;
    end
  end

  always_ff @(posedge i_bus_clk) begin
    if (lrst) begin
      o_pull_en <= PULL_W1;
    end else begin
      unique case (width_r)
        MFCI_W4: o_pull_en <= PULL_W4;
        MFCI_W8: o_pull_en <= PULL_W8;
        default: o_pull_en <= PULL_W1;
      endcase
    end
  end

endmodule // mfci_top
`default_nettype wire

// *** mfci_pkg.sv ***
/*
  Constants and types shared by the managed flash card interface.
  Assumes a SystemVerilog compiler; no module or clock is needed to use it.
*/
`default_nettype none
package mfci_pkg;

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_MHZ = 100;
  localparam int unsigned BUS_MAX_MHZ  = 52;

  // ----------------------------------------------------------------
  // Command line framing
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_LEN      = 6'h30;
  localparam logic [7:0] RSP_LONG_LEN = 8'h88;
  localparam logic [1:0] NCR_CYC      = 2'h2;
  localparam logic [5:0] IDX_GO_IDLE  = 6'h00;
  localparam logic [5:0] IDX_SEND_ID  = 6'h02;
  localparam logic [5:0] IDX_SET_ADDR = 6'h03;
  localparam logic [5:0] IDX_SWITCH   = 6'h06;
  localparam logic [5:0] RSP_RSVD     = 6'h3f;

  // ----------------------------------------------------------------
  // Extended configuration block bytes reached by the switch command
  // ----------------------------------------------------------------
  localparam logic [1:0] SW_WRITE_BYTE = 2'h3;
  localparam logic [7:0] ECB_HWRST_EN  = 8'ha2;
  localparam logic [7:0] ECB_BUS_WIDTH = 8'hb7;
  localparam logic [1:0] HWRST_ON      = 2'h1;

  // ----------------------------------------------------------------
  // Data bus width and lane masks
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MFCI_W1 = 2'b00,
    MFCI_W4 = 2'b01,
    MFCI_W8 = 2'b10
  } mfci_width_t;

  localparam logic [7:0] LANES_W1 = 8'h01;
  localparam logic [7:0] LANES_W4 = 8'h0f;
  localparam logic [7:0] LANES_W8 = 8'hff;
  localparam logic [6:0] PULL_W1  = 7'h7f;
  localparam logic [6:0] PULL_W4  = 7'h78;
  localparam logic [6:0] PULL_W8  = 7'h00;

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_RX   = 2'b01,
    L_GAP  = 2'b10,
    L_RSP  = 2'b11
  } mfci_lstate_t;

endpackage
`default_nettype wire

// *** mfci_top_sva.sv ***
/*
  Checker for mfci_top: lane groups, data beats per width, mapper timing.
  Assumes it is bound onto mfci_top and that link outputs move on bus clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module mfci_top_sva (
  input wire logic       i_ref_clk,
  input wire logic       i_srst,
  input wire logic       i_bus_clk,
  input wire logic [7:0] o_dat_out,
  input wire logic [7:0] o_dat_oe,
  input wire logic [6:0] o_pull_en,
  input wire logic       i_map_req,
  input wire logic       o_map_valid,
  input wire logic       o_ecc_err
);
  // The link side sees the core reset two bus edges late, so its checks wait too.
  logic srst_b1;
  logic srst_b2;
  logic link_rst;

  always_ff @(posedge i_bus_clk) begin
    srst_b1 <= i_srst;
    srst_b2 <= srst_b1;
  end

  assign link_rst = i_srst | srst_b2;

  // --------------------------------------------------------------
  // Link lanes
  // --------------------------------------------------------------
  chk_lanes_match: assert property (@(posedge i_bus_clk) disable iff (link_rst)
    o_dat_oe == 8'h00 || o_dat_oe == ~{o_pull_en, 1'b0}) else $error("lanes vs pulls");
  chk_pull_legal: assert property (@(posedge i_bus_clk) disable iff (link_rst)
    o_pull_en inside {7'h7f, 7'h78, 7'h00}) else $error("bad pull-up set");
  chk_start_low: assert property (@(posedge i_bus_clk) disable iff (link_rst)
    $rose(o_dat_oe[0]) |-> (o_dat_out & o_dat_oe) == 8'h00) else $error("start beat");
  chk_oe_whole: assert property (@(posedge i_bus_clk) disable iff (link_rst)
    o_dat_oe != 8'h00 && !$stable(o_dat_oe) |-> $past(o_dat_oe) == 8'h00)
    else $error("lane group changed in frame");
  chk_frame_w1: assert property (@(posedge i_bus_clk) disable iff (link_rst)
    $rose(o_dat_oe[0]) && o_dat_oe == 8'h01 |-> ##9 (o_dat_oe == 8'h01 && o_dat_out[0])
    ##1 o_dat_oe == 8'h00) else $error("x1 frame length");
  chk_frame_w4: assert property (@(posedge i_bus_clk) disable iff (link_rst)
    $rose(o_dat_oe[0]) && o_dat_oe == 8'h0f |-> ##3 (o_dat_oe == 8'h0f &&
    o_dat_out[3:0] == 4'hf) ##1 o_dat_oe == 8'h00) else $error("x4 frame length");
  chk_frame_w8: assert property (@(posedge i_bus_clk) disable iff (link_rst)
    $rose(o_dat_oe[0]) && o_dat_oe == 8'hff |-> ##2 (o_dat_oe == 8'hff &&
    o_dat_out == 8'hff) ##1 o_dat_oe == 8'h00) else $error("x8 frame length");
  // --------------------------------------------------------------
  // Core side
  // --------------------------------------------------------------
  chk_map_answer: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_map_req |-> ##[1:2] o_map_valid) else $error("no map answer");
  chk_ecc_quiet: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !o_ecc_err) else $error("parity fault on clean data");
  cover property (@(posedge i_bus_clk) o_dat_oe == 8'h0f);
  cover property (@(posedge i_bus_clk) o_dat_oe == 8'hff);
  cover property (@(posedge i_ref_clk) o_map_valid);
endmodule // mfci_top_sva
bind mfci_top mfci_top_sva mfci_top_sva_i (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_bus_clk(i_bus_clk), .o_dat_out(o_dat_out),
  .o_dat_oe(o_dat_oe), .o_pull_en(o_pull_en), .i_map_req(i_map_req),
  .o_map_valid(o_map_valid), .o_ecc_err(o_ecc_err));
`default_nettype wire

// *** mfci_host.sv ***
/*
  Host controller model: bus clock, command frames and long response capture.
  Assumes the device's command driver outputs are wired back into it.
*/
`timescale 1ns/1ps
`default_nettype none
module mfci_host (
  output logic      o_bus_clk,
  output logic      o_cmd_line,
  input  wire logic i_cmd_out,
  input  wire logic i_cmd_oe
);
  logic host_oe;
  logic host_bit;

  // --------------------------------------------------------------
  // Clock and line
  // --------------------------------------------------------------
  // The clock runs free so the device's reset synchroniser can advance.
  initial begin
    host_oe = 1'b0;
    host_bit = 1'b1;
    o_bus_clk = 1'b0;
    #7;
    forever #24 o_bus_clk = ~o_bus_clk;
  end

  // Wired-AND with a pull-up: whoever pulls low wins, which serves both modes.
  assign o_cmd_line = ((host_oe && !host_bit) || (i_cmd_oe && !i_cmd_out)) ? 1'b0 : 1'b1;

  // --------------------------------------------------------------
  // Transfers
  // --------------------------------------------------------------
  task automatic send(input logic [5:0] idx, input logic [31:0] arg);
    logic [47:0] f;
    f = {2'b01, idx, arg, 7'h00, 1'b1};
    repeat (2) @(negedge o_bus_clk);
    for (int i = 47; i >= 0; i--) begin
      @(negedge o_bus_clk);
      host_oe = 1'b1;
      host_bit = f[i];
    end
    @(negedge o_bus_clk);
    host_oe = 1'b0;
  endtask

  task automatic get_resp(output logic [135:0] r, output logic drove_hi);
    int k;
    k = 0;
    drove_hi = 1'b0;
    r = '1;
    while (o_cmd_line !== 1'b0 && k < 64) begin
      @(negedge o_bus_clk);
      k++;
    end
    for (int i = 135; i >= 0; i--) begin
      r[i] = o_cmd_line;
      drove_hi |= i_cmd_oe & i_cmd_out;
      @(negedge o_bus_clk);
    end
  endtask
endmodule // mfci_host
`default_nettype wire

// *** tb_top.sv ***
/*
  Self-checking bench for mfci_top: identity, widths, stream, pin reset, mapper.
  Assumes mfci_pkg, mfci_host and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mfci_pkg::*;
();
  localparam logic [7:0]  MAKER     = 8'h3c;             // Arbitrary value.
  localparam logic [47:0] NAME      = 48'h4142_4344_4546; // Arbitrary value.
  localparam logic [31:0] SERIAL    = 32'hc0de_0042;
  localparam logic [7:0]  MASKS [3] = '{8'h01, 8'h0f, 8'hff};
  localparam logic [6:0]  PULLS [3] = '{7'h7f, 7'h78, 7'h00};
  localparam int          WB    [3] = '{1, 4, 8};

  logic         clk, srst, hw_rst_n, bus_clk, cmd_line, cmd_out, cmd_oe, hi;
  logic         wr_valid, wr_ready, ecc_err, bad_valid, erase_done, map_req, map_valid;
  logic [7:0]   dat_out, dat_oe, wr_data, bad_blk, map_lba;
  logic [6:0]   pull_en;
  logic [8:0]   map_pba;
  logic [135:0] rsp;
  int           bad_count, n_checks, stalls;

  mfci_top #(.MAKER_CODE(MAKER), .PRODUCT_NAME(NAME), .SERIAL_NO(SERIAL)) mfci_top_i (
    .i_ref_clk(clk), .i_srst(srst), .i_bus_clk(bus_clk), .i_hw_rst_n(hw_rst_n),
    .i_cmd_in(cmd_line), .o_cmd_out(cmd_out), .o_cmd_oe(cmd_oe), .i_dat_in(8'hff),
    .o_dat_out(dat_out), .o_dat_oe(dat_oe), .o_pull_en(pull_en), .i_wr_data(wr_data),
    .i_wr_valid(wr_valid), .o_wr_ready(wr_ready), .o_ecc_err(ecc_err),
    .i_bad_valid(bad_valid), .i_bad_blk(bad_blk), .i_erase_done(erase_done),
    .i_map_req(map_req), .i_map_lba(map_lba), .o_map_pba(map_pba), .o_map_valid(map_valid));
  mfci_host mfci_host_i (.o_bus_clk(bus_clk), .o_cmd_line(cmd_line), .i_cmd_out(cmd_out),
    .i_cmd_oe(cmd_oe));

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic cmp(input logic [135:0] got, input logic [135:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic       f;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      f = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (f ? 7'h09 : 7'h00);
    end
    return c;
  endfunction

  task automatic send_byte(input logic [7:0] b);
    int k;
    k = 0;
    wr_data <= b;
    wr_valid <= 1'b1;
    @(negedge clk);
    while (wr_ready !== 1'b1 && k < 500) begin
      stalls++;
      @(negedge clk);
      k++;
    end
    @(posedge clk);
  endtask

  task automatic get_byte(input int wb, input logic [7:0] m, output logic [7:0] b);
    int k;
    k = 0;
    b = 8'h00;
    @(negedge bus_clk);
    while (dat_oe === 8'h00 && k < 400) begin
      @(negedge bus_clk);
      k++;
    end
    cmp(dat_oe, m);
    cmp(dat_out & m, 8'h00);
    repeat (8 / wb) begin
      @(negedge bus_clk);
      b = (b << wb) | (dat_out & m);
    end
    @(negedge bus_clk);
    cmp(dat_out & dat_oe, m);
  endtask

  task automatic stream(input int w);
    logic [7:0] got;
    stalls = 0;
    fork
      begin
        @(posedge clk);
        // Four bytes overfill the two-entry buffer, so the last one must stall.
        for (int j = 0; j < 4; j++) send_byte(8'h5a + 8'h33 * j[7:0]);
        wr_valid <= 1'b0;
      end
      for (int j = 0; j < 4; j++) begin
        get_byte(WB[w], MASKS[w], got);
        cmp(got, 8'h5a + 8'h33 * j[7:0]);
      end
    join
    cmp(stalls != 0, 1'b1);
  endtask

  task automatic set_byte(input logic [7:0] idx, input logic [7:0] v);
    mfci_host_i.send(IDX_SWITCH, {6'h00, SW_WRITE_BYTE, idx, v, 8'h00});
    repeat (4) @(negedge bus_clk);
  endtask

  task automatic pin(input logic v);
    @(posedge clk);
    hw_rst_n <= v;
    repeat (8) @(negedge bus_clk);
  endtask

  task automatic map_check(input logic [7:0] lba, input logic [8:0] exp);
    int k;
    k = 0;
    @(posedge clk);
    map_req <= 1'b1;
    map_lba <= lba;
    @(posedge clk);
    map_req <= 1'b0;
    @(negedge clk);
    while (map_valid !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    cmp(map_valid, 1'b1);
    cmp(map_pba, exp);
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Clock, watchdog and tests
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial begin
    {srst, hw_rst_n} = 2'b11;
    {wr_valid, bad_valid, erase_done, map_req} = 4'h0;
    {wr_data, bad_blk, map_lba} = 24'h000000;
    // Reset spans three bus periods so the link side sees it as well.
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (40) @(posedge clk);
    cmp(pull_en, 7'h7f);
    cmp(dat_oe, 8'h00);
    for (int p = 0; p < 2; p++) begin
      if (p == 1) mfci_host_i.send(IDX_SET_ADDR, 32'h0001_0000);
      mfci_host_i.send(IDX_SEND_ID, 32'h0000_0000);
      mfci_host_i.get_resp(rsp, hi);
      cmp(hi, p[0]);
      cmp(rsp[135:128], 8'h3f);
      cmp(rsp[127:120], MAKER);
      cmp(rsp[119:114], 6'h00);
      cmp(rsp[103:56], NAME);
      cmp(rsp[47:16], SERIAL);
      cmp(rsp[7:0], {crc7(rsp[127:8]), 1'b1});
    end
    map_check(8'h10, 9'h010);
    @(posedge clk) erase_done <= 1'b1;
    @(posedge clk) erase_done <= 1'b0;
    map_check(8'h10, 9'h011);
    @(posedge clk) {bad_valid, bad_blk} <= 9'h111;
    @(posedge clk) bad_valid <= 1'b0;
    map_check(8'h10, 9'h100);
    map_check(8'hff, 9'h000);
    for (int w = 0; w < 3; w++) begin
      if (w > 0) set_byte(ECB_BUS_WIDTH, w[7:0]);
      cmp(pull_en, PULLS[w]);
      stream(w);
    end
    pin(1'b0);
    cmp(pull_en, 7'h00);
    pin(1'b1);
    set_byte(ECB_HWRST_EN, {6'h00, HWRST_ON});
    pin(1'b0);
    cmp(pull_en, 7'h7f);
    pin(1'b1);
    stream(0);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
